// ==== gpsc_defines.svh ====
`ifndef GPSC_DEFINES_SVH
`define GPSC_DEFINES_SVH

// Register byte offsets (12-bit address space)
`define GPSC_OFS_OUT 12'h504
`define GPSC_OFS_OUT_SET 12'h508
`define GPSC_OFS_OUT_CLR 12'h50C
`define GPSC_OFS_IN 12'h510
`define GPSC_OFS_DIR 12'h514
`define GPSC_OFS_DIR_SET 12'h518
`define GPSC_OFS_DIR_CLR 12'h51C
`define GPSC_OFS_MATCH 12'h520
`define GPSC_OFS_WAKE_SEL 12'h524
`define GPSC_OFS_SENSE_LO 12'h600
`define GPSC_OFS_SENSE_HI 12'h604
`define GPSC_OFS_IRQ_STAT 12'h608
`define GPSC_OFS_IRQ_MASK 12'h60C

// Reset values
`define GPSC_RST_WORD 32'h0000_0000

// Sense field encodings, two bits per pin
`define GPSC_SENSE_OFF 2'h0
`define GPSC_SENSE_HIGH 2'h2
`define GPSC_SENSE_LOW 2'h3

// Interrupt status bit positions
`define GPSC_IRQ_BIT_MATCH 0
`define GPSC_IRQ_BIT_WAKE 1

`endif

// ==== gpsc_pkg.sv ====
package gpsc_pkg;

  // Register bus request from software
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gpsc_bus_req_s;

  // Decoded register selector
  typedef enum logic [3:0] {
    GPSC_REG_NONE = 4'h0,
    GPSC_REG_OUT = 4'h1,
    GPSC_REG_OUT_SET = 4'h2,
    GPSC_REG_OUT_CLR = 4'h3,
    GPSC_REG_IN = 4'h4,
    GPSC_REG_DIR = 4'h5,
    GPSC_REG_DIR_SET = 4'h6,
    GPSC_REG_DIR_CLR = 4'h7,
    GPSC_REG_MATCH = 4'h8,
    GPSC_REG_WAKE_SEL = 4'h9,
    GPSC_REG_SENSE_LO = 4'hA,
    GPSC_REG_SENSE_HI = 4'hB,
    GPSC_REG_IRQ_STAT = 4'hC,
    GPSC_REG_IRQ_MASK = 4'hD
  } gpsc_reg_e;

endpackage

// ==== gpsc_pin_sync.sv ====
`timescale 1ns/10ps
`include "gpsc_defines.svh"

// Two-stage synchroniser for the asynchronous pin levels
module gpsc_pin_sync #(
  parameter int WIDTH = 32
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== gpsc_port.sv ====
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "gpsc_defines.svh"

// Contract
// - A one written to the output-clear alias drives that pin's output value low; zeros do nothing.
// - Reading the output-clear alias returns the output value register.
// - The input register is read-only and shows the sampled level of all 32 pins.
// - The direction register is read-write, one means output, and it resets to zero.
// - A one written to the direction-set alias makes that pin an output; zeros do nothing.
// - A one written to the direction-clear alias makes that pin an input; zeros do nothing.
// - Reading either direction alias returns the direction register.
// - A pin's sense-match bit is set whenever the pin meets its selected sense level.
// - With the wake source select at zero, wake-detect follows the live per-pin detects.
// - With the wake source select at one, wake-detect follows the held signal instead.
module gpsc_port #(
  parameter int PINS = 32
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_out,
  output logic wake_detect_out,
  output logic irq_out
);

  // Latency: a pin change reaches the input register after two edges,
  // the record and the wake output after three; read data follow the
  // strobe by one edge and fall back to zero after it, so software
  // never sees a stale word on an idle bus.

  // Bus request and decode
  gpsc_pkg::gpsc_bus_req_s req;
  gpsc_pkg::gpsc_reg_e sel;

  // Synchronised pins and port registers
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] out_q;
  logic [PINS-1:0] dir_q;

  // Sense configuration, record and live detects
  logic [PINS-1:0] match_q;
  logic [PINS-1:0] match_d;
  logic [PINS-1:0] live_detect;
  logic [2*PINS-1:0] sense_q;

  // Wake source and output
  logic wake_sel_q;
  logic wake_d;
  logic wake_prev_q;

  // Interrupt status, mask and events
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_event;

  // Read path
  logic [31:0] rdata_d;

  // Address decode, shared by write and read paths
  function automatic gpsc_pkg::gpsc_reg_e decode(input logic [11:0] a);
    case (a)
      `GPSC_OFS_OUT: decode = gpsc_pkg::GPSC_REG_OUT;
      `GPSC_OFS_OUT_SET: decode = gpsc_pkg::GPSC_REG_OUT_SET;
      `GPSC_OFS_OUT_CLR: decode = gpsc_pkg::GPSC_REG_OUT_CLR;
      `GPSC_OFS_IN: decode = gpsc_pkg::GPSC_REG_IN;
      `GPSC_OFS_DIR: decode = gpsc_pkg::GPSC_REG_DIR;
      `GPSC_OFS_DIR_SET: decode = gpsc_pkg::GPSC_REG_DIR_SET;
      `GPSC_OFS_DIR_CLR: decode = gpsc_pkg::GPSC_REG_DIR_CLR;
      `GPSC_OFS_MATCH: decode = gpsc_pkg::GPSC_REG_MATCH;
      `GPSC_OFS_WAKE_SEL: decode = gpsc_pkg::GPSC_REG_WAKE_SEL;
      `GPSC_OFS_SENSE_LO: decode = gpsc_pkg::GPSC_REG_SENSE_LO;
      `GPSC_OFS_SENSE_HI: decode = gpsc_pkg::GPSC_REG_SENSE_HI;
      `GPSC_OFS_IRQ_STAT: decode = gpsc_pkg::GPSC_REG_IRQ_STAT;
      `GPSC_OFS_IRQ_MASK: decode = gpsc_pkg::GPSC_REG_IRQ_MASK;
      default: decode = gpsc_pkg::GPSC_REG_NONE;
    endcase
  endfunction

  // Zero-extend a per-pin vector to a bus word, so a narrower port reads clean
  function automatic logic [31:0] to_word(input logic [PINS-1:0] v);
    to_word = '0;
    to_word[PINS-1:0] = v;
  endfunction

  // Bundle bus inputs
  assign req.addr = addr_in;
  assign req.wdata = wdata_in;
  assign req.wr = wr_in;
  assign req.rd = rd_in;
  assign sel = decode(req.addr);

  // Pins are asynchronous to clk_in
  // Two flops cost two cycles but keep metastable levels out of the record
  gpsc_pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // Per-pin level criterion from the two-bit sense field
  // Field value 1 is reserved and treated as off
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_sense
      always_comb begin
        case (sense_q[2*gi +: 2])
          `GPSC_SENSE_HIGH: live_detect[gi] = pin_sync[gi];
          `GPSC_SENSE_LOW: live_detect[gi] = ~pin_sync[gi];
          default: live_detect[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Output value register with set and clear aliases
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_q <= '0;
    end else if (req.wr) begin
      case (sel)
        gpsc_pkg::GPSC_REG_OUT: out_q <= req.wdata[PINS-1:0];
        gpsc_pkg::GPSC_REG_OUT_SET: out_q <= out_q | req.wdata[PINS-1:0];
        gpsc_pkg::GPSC_REG_OUT_CLR: out_q <= out_q & ~req.wdata[PINS-1:0];
        default: out_q <= out_q;
      endcase
    end
  end

  // Direction register, shared by plain write and both aliases
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dir_q <= '0;
    end else if (req.wr) begin
      case (sel)
        gpsc_pkg::GPSC_REG_DIR: dir_q <= req.wdata[PINS-1:0];
        gpsc_pkg::GPSC_REG_DIR_SET: dir_q <= dir_q | req.wdata[PINS-1:0];
        gpsc_pkg::GPSC_REG_DIR_CLR: dir_q <= dir_q & ~req.wdata[PINS-1:0];
        default: dir_q <= dir_q;
      endcase
    end
  end

  // Sense configuration, two words of two-bit fields
  // Word split is fixed at bit 32, so PINS must stay 32
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sense_q <= '0;
    end else if (req.wr && sel == gpsc_pkg::GPSC_REG_SENSE_LO) begin
      sense_q[31:0] <= req.wdata;
    end else if (req.wr && sel == gpsc_pkg::GPSC_REG_SENSE_HI) begin
      sense_q[63:32] <= req.wdata;
    end
  end

  // Sense-match record: a live match wins over a clear in the same cycle
  always_comb begin
    match_d = match_q;
    if (req.wr && sel == gpsc_pkg::GPSC_REG_MATCH) begin
      match_d = match_q & ~req.wdata[PINS-1:0];
    end
    match_d = match_d | live_detect;
  end

  // Record flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      match_q <= '0;
    end else begin
      match_q <= match_d;
    end
  end

  // Wake source select
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_sel_q <= 1'b0;
    end else if (req.wr && sel == gpsc_pkg::GPSC_REG_WAKE_SEL) begin
      wake_sel_q <= req.wdata[0];
    end
  end

  // Held mode reads the record, so it stays up until every bit is cleared
  always_comb begin
    if (wake_sel_q) begin
      wake_d = |match_d;
    end else begin
      wake_d = |live_detect;
    end
  end

  // Wake output straight from a flop
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_detect_out <= 1'b0;
    end else begin
      wake_detect_out <= wake_d;
    end
  end

  // Previous wake level; resets to idle so no false edge follows reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= wake_d;
    end
  end

  // Events: a newly set record bit, and a wake rising edge
  // Both use next-state values so status sets on the same edge as the record
  assign irq_event[`GPSC_IRQ_BIT_MATCH] = |(match_d & ~match_q);
  assign irq_event[`GPSC_IRQ_BIT_WAKE] = wake_d & ~wake_prev_q;

  // Sticky status, cleared by read; a new event beats the read
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_q <= '0;
    end else if (req.rd && sel == gpsc_pkg::GPSC_REG_IRQ_STAT) begin
      irq_stat_q <= irq_event;
    end else begin
      irq_stat_q <= irq_stat_q | irq_event;
    end
  end

  // Interrupt mask, one bit per event
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask_q <= '0;
    end else if (req.wr && sel == gpsc_pkg::GPSC_REG_IRQ_MASK) begin
      irq_mask_q <= req.wdata[1:0];
    end
  end

  // Registered interrupt level, one cycle behind the status
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Pad value from a flop, one cycle behind the output register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_out <= '0;
    end else begin
      pin_out <= out_q;
    end
  end

  // Pad enable from a flop, high while the pin drives
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_oe_out <= '0;
    end else begin
      pin_oe_out <= dir_q;
    end
  end

  // Read mux; unmapped locations read zero, set and clear aliases read their base register
  always_comb begin
    rdata_d = `GPSC_RST_WORD;
    case (sel)
      gpsc_pkg::GPSC_REG_OUT: rdata_d = to_word(out_q);
      gpsc_pkg::GPSC_REG_OUT_SET: rdata_d = to_word(out_q);
      gpsc_pkg::GPSC_REG_OUT_CLR: rdata_d = to_word(out_q);
      gpsc_pkg::GPSC_REG_IN: rdata_d = to_word(pin_sync);
      gpsc_pkg::GPSC_REG_DIR: rdata_d = to_word(dir_q);
      gpsc_pkg::GPSC_REG_DIR_SET: rdata_d = to_word(dir_q);
      gpsc_pkg::GPSC_REG_DIR_CLR: rdata_d = to_word(dir_q);
      gpsc_pkg::GPSC_REG_MATCH: rdata_d = to_word(match_q);
      gpsc_pkg::GPSC_REG_WAKE_SEL: rdata_d = {31'h0000_0000, wake_sel_q};
      gpsc_pkg::GPSC_REG_SENSE_LO: rdata_d = sense_q[31:0];
      gpsc_pkg::GPSC_REG_SENSE_HI: rdata_d = sense_q[63:32];
      gpsc_pkg::GPSC_REG_IRQ_STAT: rdata_d = {30'h0000_0000, irq_stat_q};
      gpsc_pkg::GPSC_REG_IRQ_MASK: rdata_d = {30'h0000_0000, irq_mask_q};
      default: rdata_d = `GPSC_RST_WORD;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  // Zero outside that cycle lets the bus OR several slaves together
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= `GPSC_RST_WORD;
    end else if (req.rd) begin
      rdata_out <= rdata_d;
    end else begin
      rdata_out <= `GPSC_RST_WORD;
    end
  end

endmodule

// ==== gpsc_port_props.sv ====
`timescale 1ns/10ps
// Checks on the register bus and the pad outputs
module gpsc_port_props #(
  parameter int PINS = 32
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_out,
  input wire logic wake_detect_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  AST_RD_DIR: assert property (
    rd_in && addr_in inside {12'h514, 12'h518, 12'h51C} |=> rdata_out == pin_oe_out)
    else $error("direction read differs from enables");
  AST_RD_OUT: assert property (rd_in && addr_in == 12'h50C |=> rdata_out == pin_out)
    else $error("output clear read differs from pads");
  AST_UNMAPPED: assert property (rd_in && addr_in == 12'h7FC |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_DIR_SET: assert property (wr_in && addr_in == 12'h518 ##1 !wr_in
    |=> (pin_oe_out & $past(wdata_in, 2)) == $past(wdata_in, 2))
    else $error("direction set bits not driving");
  AST_DIR_CLR: assert property (wr_in && addr_in == 12'h51C ##1 !wr_in
    |=> (pin_oe_out & $past(wdata_in, 2)) == 32'h0)
    else $error("direction clear bits still driving");
  AST_OUT_CLR: assert property (wr_in && addr_in == 12'h50C ##1 !wr_in
    |=> (pin_out & $past(wdata_in, 2)) == 32'h0)
    else $error("output clear bits still high");
  AST_RST: assert property ($rose(reset_n_in) |-> pin_oe_out == 0 && pin_out == 0)
    else $error("pads active right after reset");
endmodule

bind gpsc_port gpsc_port_props #(.PINS(PINS)) u_props (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .pin_in(pin_in),
  .pin_out(pin_out),
  .pin_oe_out(pin_oe_out),
  .wake_detect_out(wake_detect_out),
  .irq_out(irq_out)
);

// ==== gpsc_ext_pins.sv ====
`timescale 1ns/10ps
// Board circuitry: drives each pad the port leaves undriven
module gpsc_ext_pins (
  input wire logic [31:0] level_in,
  input wire logic [31:0] drv_in,
  input wire logic [31:0] oe_in,
  output logic [31:0] pad_out
);
  // A driven pad reads back its own level, so no fight is modelled
  assign pad_out = (oe_in & drv_in) | (~oe_in & level_in);
endmodule

// ==== gpsc_port_bench.sv ====
`timescale 1ns/10ps
module gpsc_port_bench;
  logic clk_in, reset_n_in, wr_in, rd_in, wake_detect_out, irq_out;
  logic [11:0] addr_in;
  logic [31:0] wdata_in, rdata_out, pin_in, pin_out, pin_oe_out, ext;
  int fails, n_tests;

  gpsc_port u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .wake_detect_out(wake_detect_out), .irq_out(irq_out));
  gpsc_ext_pins u_ext (.level_in(ext), .drv_in(pin_out), .oe_in(pin_oe_out),
    .pad_out(pin_in));

  // 50 MHz system clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe, released before the next call
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, rdata_out);
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Tests need under two hundred cycles; allow 5000
  initial begin
    #100000;
    fails++;
    conclude();
  end

  initial begin
    reset_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 12'h0;
    wdata_in = 32'h0;
    ext = 32'h0;
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(12'h514, 32'h0);
    rd(12'h520, 32'h0);
    rd(12'h50C, 32'h0);
    rd(12'h7FC, 32'h0);
    $display("test reset done");
    wr(12'h514, 32'hF0F0F0F0);
    rd(12'h514, 32'hF0F0F0F0);
    wr(12'h518, 32'h0000000F);
    rd(12'h518, 32'hF0F0F0FF);
    wr(12'h51C, 32'h80000001);
    rd(12'h51C, 32'h70F0F0FE);
    chk("pin_oe_out", 32'h70F0F0FE, pin_oe_out);
    $display("test direction done");
    wr(12'h504, 32'hFFFFFFFF);
    wr(12'h50C, 32'h0000FF00);
    rd(12'h50C, 32'hFFFF00FF);
    chk("pin_out", 32'hFFFF00FF, pin_out);
    rd(12'h510, 32'h70F000FE);
    $display("test output done");
    wr(12'h51C, 32'hFFFFFFFF);
    ext <= 32'hA5A53C3C;
    w(4);
    rd(12'h510, 32'hA5A53C3C);
    wr(12'h510, 32'h0);
    rd(12'h510, 32'hA5A53C3C);
    $display("test input done");
    // Pin 0 senses high, pin 1 senses low; start with neither matching
    ext <= 32'h2;
    wr(12'h600, 32'h0000000E);
    w(6);
    chk("wake", 32'h0, {31'h0, wake_detect_out});
    ext <= 32'h1;
    w(6);
    chk("wake", 32'h1, {31'h0, wake_detect_out});
    chk("irq", 32'h0, {31'h0, irq_out});
    rd(12'h520, 32'h3);
    ext <= 32'h2;
    w(6);
    chk("wake", 32'h0, {31'h0, wake_detect_out});
    wr(12'h60C, 32'h1);
    w(3);
    chk("irq", 32'h1, {31'h0, irq_out});
    rd(12'h608, 32'h3);
    w(3);
    chk("irq", 32'h0, {31'h0, irq_out});
    wr(12'h520, 32'h1);
    rd(12'h520, 32'h2);
    wr(12'h524, 32'h1);
    w(4);
    chk("wake", 32'h1, {31'h0, wake_detect_out});
    rd(12'h524, 32'h1);
    wr(12'h520, 32'h2);
    w(4);
    chk("wake", 32'h0, {31'h0, wake_detect_out});
    rd(12'h520, 32'h0);
    $display("test detect done");
    // Wake event on an upper pin, seen through the mask
    rd(12'h608, 32'h2);
    wr(12'h60C, 32'h2);
    wr(12'h508, 32'h00000F00);
    rd(12'h504, 32'hFFFF0FFF);
    wr(12'h604, 32'h00000002);
    chk("irq", 32'h0, {31'h0, irq_out});
    ext <= 32'h00010002;
    w(6);
    chk("wake", 32'h1, {31'h0, wake_detect_out});
    rd(12'h520, 32'h00010000);
    chk("irq", 32'h1, {31'h0, irq_out});
    $display("test upper pin done");
    // Mid-run reset returns every register to zero
    wr(12'h518, 32'h0000FFFF);
    rd(12'h514, 32'h0000FFFF);
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(12'h514, 32'h0);
    chk("pin_oe_out", 32'h0, pin_oe_out);
    rd(12'h520, 32'h0);
    rd(12'h524, 32'h0);
    rd(12'h504, 32'h0);
    chk("wake", 32'h0, {31'h0, wake_detect_out});
    chk("irq", 32'h0, {31'h0, irq_out});
    $display("test second reset done");
    conclude();
  end
endmodule
